// >>> hw/osc_dev.sv
`timescale 1ns/1ns
`default_nettype none
module osc_dev (
   // Clock and power-on reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Analog comparator and ID pin levels.
   input wire logic id_pin,
   input wire logic vbus_valid_cmp,
   input wire logic sess_valid_cmp,
   input wire logic session_end_flag_cmp,
   // Analog control outputs.
   output logic id_sense_pull_enable,
   output logic vbus_discharge_ctrl,
   output logic vbus_charge_ctrl,
   // Bus to link.
   osc_ulpi_if.dev bus
);
   logic [3:0] cmp_sync;
   logic [1:0] div_reg;
   logic clk_en_reg;
   logic [7:0] por_cnt_reg;
   osc_pkg::osc_dev_state_t st_reg;
   logic [3:0] last_reg;
   logic pend_reg;
   logic [3:0] cmd_reg;
   logic dir_reg;
   logic [3:0] dout_reg;
   logic [3:0] oe_n_reg;
   logic [3:0] ctl_reg;
   logic [3:0] status_now;
   logic id_grounded_flag;
   logic changed;
   logic por_done;

   // Comparators cross into the interface clock before anything reads them.
   osc_sync2 #(.W(4)) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d({id_pin, vbus_valid_cmp, sess_valid_cmp, session_end_flag_cmp}),
      .q(cmp_sync)
   );

   // ID ground is the inverse of the pulled-up pin, masked while sensing is off.
   assign id_grounded_flag = ctl_reg[osc_pkg::CTL_ID_PULL_BIT] & ~cmp_sync[3];
   assign status_now = {id_grounded_flag, cmp_sync[2], cmp_sync[1], cmp_sync[0]};
   assign changed = status_now != last_reg;
   assign por_done = por_cnt_reg == 8'(osc_pkg::POR_CYCLES);
   assign id_sense_pull_enable = ctl_reg[osc_pkg::CTL_ID_PULL_BIT];
   assign vbus_discharge_ctrl = ctl_reg[osc_pkg::CTL_DISCHRG_BIT];
   assign vbus_charge_ctrl = ctl_reg[osc_pkg::CTL_CHRG_BIT];
   assign bus.clk_en = clk_en_reg;
   assign bus.dir = dir_reg;
   assign bus.dev_data_o = dout_reg;
   assign bus.dev_data_oe_n = oe_n_reg;

   // Divider makes the interface rate as a one-cycle enable.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_reg <= 2'h0;
         clk_en_reg <= 1'b0;
      end else begin
         div_reg <= (div_reg + 2'h1 >= osc_pkg::CLK_DIV) ? 2'h0 : div_reg + 2'h1;
         clk_en_reg <= (div_reg + 2'h1 >= osc_pkg::CLK_DIV);
      end
   end

   // Reset holds the bus blocked, then a stretch keeps it so while power settles.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         por_cnt_reg <= 8'h00;
      end else if (!por_done) begin
         por_cnt_reg <= por_cnt_reg + 8'h01;
      end
   end

   // Main sequencer; a link command is a command nibble then a data nibble.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= osc_pkg::D_BLOCK;
         last_reg <= 4'h0;
         pend_reg <= 1'b0;
         cmd_reg <= osc_pkg::CMD_IDLE;
         ctl_reg <= osc_pkg::CTL_RESET;
         dir_reg <= 1'b1;
         dout_reg <= 4'h0;
         oe_n_reg <= 4'hF;
      end else if (clk_en_reg) begin
         case (st_reg)
            osc_pkg::D_BLOCK: begin
               dir_reg <= 1'b1;
               if (por_done) begin
                  st_reg <= osc_pkg::D_LISTEN;
                  dir_reg <= 1'b0;
               end
            end
            osc_pkg::D_LISTEN: begin
               if (pend_reg) begin
                  // The nibble after a command nibble is its second half, zero or not.
                  pend_reg <= 1'b0;
                  if (cmd_reg == osc_pkg::CMD_RESET) begin
                     ctl_reg <= osc_pkg::CTL_RESET;
                     last_reg <= 4'h0;
                  end else if (cmd_reg == osc_pkg::CMD_CTRL_WR) begin
                     ctl_reg <= bus.data;
                  end
               end else if (bus.data != osc_pkg::CMD_IDLE) begin
                  cmd_reg <= bus.data;
                  pend_reg <= 1'b1;
               end else if (changed) begin
                  // Status goes out only when idle, so a command the device has already seen is never cut in two.
                  st_reg <= osc_pkg::D_RXC_LO;
                  dir_reg <= 1'b1;
                  last_reg <= status_now;
               end
            end
            osc_pkg::D_RXC_LO: begin
               // First cycle after turnaround: drive the status nibble.
               oe_n_reg <= 4'h0;
               dout_reg <= last_reg;
               st_reg <= osc_pkg::D_RXC_HI;
            end
            osc_pkg::D_RXC_HI: begin
               oe_n_reg <= 4'hF;
               dout_reg <= 4'h0;
               dir_reg <= 1'b0;
               st_reg <= osc_pkg::D_LISTEN;
            end
            default: begin
               st_reg <= osc_pkg::D_BLOCK;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> hw/osc_link.sv
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module osc_link (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Software register port.
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Role and interrupt.
   output logic host_role,
   output logic irq,
   // Bus to transceiver.
   osc_ulpi_if.link bus
);
   osc_pkg::osc_link_state_t st_reg;
   logic [3:0] ctl_reg;
   logic ctl_dirty_reg;
   logic [3:0] stat_reg;
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_en_reg;
   logic [1:0] srp_reg;
   logic [3:0] dout_reg;
   logic [3:0] oe_n_reg;
   logic [7:0] rdata_reg;
   logic host_reg;
   logic irq_reg;
   logic dir_q_reg;
   logic sent_reset_reg;
   logic [2:0] ev_set;
   logic [3:0] ctl_next;
   logic [7:0] rd_mux;
   logic wr_ctrl;
   logic wr_srp;

   assign wr_ctrl = reg_wr && reg_addr == osc_pkg::REG_CTRL;
   assign wr_srp = reg_wr && reg_addr == osc_pkg::REG_SRP;
   // Session request: phase 1 discharge until session end, phase 2 charge.
   assign ctl_next = {1'b0, srp_reg[1], srp_reg[0], ctl_reg[osc_pkg::CTL_ID_PULL_BIT]};
   assign rd_mux = (reg_addr == osc_pkg::REG_CTRL) ? {4'h0, ctl_reg} :
                   (reg_addr == osc_pkg::REG_STATUS) ? {3'h0, host_reg, stat_reg} :
                   (reg_addr == osc_pkg::REG_IRQ_STAT) ? {5'h00, irq_stat_reg} :
                   (reg_addr == osc_pkg::REG_IRQ_EN) ? {5'h00, irq_en_reg} :
                   (reg_addr == osc_pkg::REG_SRP) ? {6'h00, srp_reg} : 8'h00;
   assign reg_rdata = rdata_reg;
   assign host_role = host_reg;
   assign irq = irq_reg;
   assign bus.link_data_o = dout_reg;
   assign bus.link_data_oe_n = oe_n_reg;

   // Register port and interrupt bookkeeping; a set beats a same-cycle clear.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         irq_en_reg <= 3'h0;
         irq_stat_reg <= 3'h0;
         irq_reg <= 1'b0;
      end else begin
         rdata_reg <= reg_rd ? rd_mux : 8'h00;
         if (reg_wr && reg_addr == osc_pkg::REG_IRQ_EN) begin
            irq_en_reg <= reg_wdata[2:0];
         end
         irq_stat_reg <= ((reg_wr && reg_addr == osc_pkg::REG_IRQ_CLR) ?
                          (irq_stat_reg & ~reg_wdata[2:0]) : irq_stat_reg) | ev_set;
         irq_reg <= |(irq_stat_reg & irq_en_reg);
      end
   end

   // Bus side: reset command first, then control writes and status capture.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= osc_pkg::L_RESET_CMD;
         ctl_reg <= osc_pkg::CTL_RESET;
         ctl_dirty_reg <= 1'b0;
         stat_reg <= 4'h0;
         srp_reg <= 2'h0;
         dout_reg <= 4'h0;
         oe_n_reg <= 4'hF;
         host_reg <= 1'b0;
         dir_q_reg <= 1'b1;
         sent_reset_reg <= 1'b0;
         ev_set <= 3'h0;
      end else begin
         ev_set <= 3'h0;
         if (wr_ctrl) begin
            ctl_reg[osc_pkg::CTL_ID_PULL_BIT] <= reg_wdata[osc_pkg::CTL_ID_PULL_BIT];
            ctl_dirty_reg <= 1'b1;
         end
         if (wr_srp && srp_reg == 2'h0) begin
            srp_reg <= 2'h1;
            ctl_dirty_reg <= 1'b1;
         end
         if (bus.clk_en) begin
            dir_q_reg <= bus.dir;
            case (st_reg)
               osc_pkg::L_RESET_CMD: begin
                  // Idle low while the bus is ours, off it while the device blocks or sends status.
                  oe_n_reg <= bus.dir ? 4'hF : 4'h0;
                  if (!bus.dir && !dir_q_reg && !sent_reset_reg) begin
                     oe_n_reg <= 4'h0;
                     dout_reg <= osc_pkg::CMD_RESET;
                     sent_reset_reg <= 1'b1;
                     st_reg <= osc_pkg::L_DATA;
                  end
               end
               osc_pkg::L_IDLE: begin
                  oe_n_reg <= 4'h0;
                  dout_reg <= osc_pkg::CMD_IDLE;
                  if (bus.dir) begin
                     // The status nibble stands only one enable, so capture comes next.
                     oe_n_reg <= 4'hF;
                     st_reg <= osc_pkg::L_RXC;
                  end else if (ctl_dirty_reg) begin
                     dout_reg <= osc_pkg::CMD_CTRL_WR;
                     ctl_reg <= ctl_next;
                     ctl_dirty_reg <= 1'b0;
                     st_reg <= osc_pkg::L_CMD;
                  end
               end
               osc_pkg::L_CMD: begin
                  if (bus.dir) begin
                     // The device took the bus under the command nibble; yield and retry later.
                     oe_n_reg <= 4'hF;
                     ctl_dirty_reg <= 1'b1;
                     st_reg <= osc_pkg::L_RXC;
                  end else begin
                     dout_reg <= ctl_reg;
                     st_reg <= osc_pkg::L_DATA;
                  end
               end
               osc_pkg::L_DATA: begin
                  dout_reg <= osc_pkg::CMD_IDLE;
                  st_reg <= osc_pkg::L_IDLE;
               end
               osc_pkg::L_TURN: begin
                  st_reg <= osc_pkg::L_RXC;
               end
               osc_pkg::L_RXC: begin
                  // Status nibble; vbus valid is kept only as status, never acted on.
                  stat_reg <= bus.data;
                  ev_set[osc_pkg::IRQ_STAT_BIT] <= 1'b1;
                  host_reg <= ~bus.data[osc_pkg::RX_ID_GROUNDED_FLAG_BIT];
                  ev_set[osc_pkg::IRQ_ROLE_BIT] <= host_reg == bus.data[osc_pkg::RX_ID_GROUNDED_FLAG_BIT];
                  if (srp_reg == 2'h1 && bus.data[osc_pkg::RX_SESSION_END_FLAG_BIT]) begin
                     srp_reg <= 2'h2;
                     ctl_dirty_reg <= 1'b1;
                  end else if (srp_reg == 2'h2 && bus.data[osc_pkg::RX_SESS_VLD_BIT]) begin
                     srp_reg <= 2'h0;
                     ctl_dirty_reg <= 1'b1;
                     ev_set[osc_pkg::IRQ_SRP_BIT] <= 1'b1;
                  end
                  st_reg <= osc_pkg::L_IDLE;
               end
               default: begin
                  st_reg <= osc_pkg::L_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// >>> hw/osc_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module osc_sync2 #(parameter int W = 4) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Asynchronous in, synchronous out.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   // Two stages; only the second stage reads the first.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// >>> inc/osc_pkg.sv
package osc_pkg;
   // Interface clock rate and clock divider for the interface clock enable.
   localparam int SYS_CLK_HZ = 25000000;
   localparam int ULPI_CLK_HZ = 60000000;
   // The interface clock cannot be made from 25 MHz; one enable every cycle stands in for it.
   localparam logic [1:0] CLK_DIV = 2'h1;
   // Power-on reset stretch in cycles.
   localparam int POR_TIME_NS = 400;
   localparam int POR_CYCLES = (POR_TIME_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
   // RXCMD status nibble layout, sent as a single nibble on the data bus.
   localparam int RX_SESSION_END_FLAG_BIT = 0;
   localparam int RX_SESS_VLD_BIT = 1;
   localparam int RX_VBUS_VLD_BIT = 2;
   localparam int RX_ID_GROUNDED_FLAG_BIT = 3;
   // Transmit command nibbles sent by the link.
   localparam logic [3:0] CMD_IDLE = 4'h0;
   localparam logic [3:0] CMD_RESET = 4'h1;
   localparam logic [3:0] CMD_CTRL_WR = 4'h2;
   // Control nibble layout carried by a control write.
   localparam int CTL_ID_PULL_BIT = 0;
   localparam int CTL_DISCHRG_BIT = 1;
   localparam int CTL_CHRG_BIT = 2;
   localparam logic [3:0] CTL_RESET = 4'h0;
   // Link software register offsets.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_IRQ_STAT = 4'h2;
   localparam logic [3:0] REG_IRQ_CLR = 4'h3;
   localparam logic [3:0] REG_IRQ_EN = 4'h4;
   localparam logic [3:0] REG_SRP = 4'h5;
   // Interrupt bits: status change, srp done, role change.
   localparam int IRQ_STAT_BIT = 0;
   localparam int IRQ_SRP_BIT = 1;
   localparam int IRQ_ROLE_BIT = 2;
   // Device state machine.
   typedef enum logic [3:0] {
      D_BLOCK = 4'h1,
      D_LISTEN = 4'h2,
      D_RXC_LO = 4'h4,
      D_RXC_HI = 4'h8
   } osc_dev_state_t;
   // Link state machine.
   typedef enum logic [5:0] {
      L_RESET_CMD = 6'h01,
      L_IDLE = 6'h02,
      L_CMD = 6'h04,
      L_DATA = 6'h08,
      L_TURN = 6'h10,
      L_RXC = 6'h20
   } osc_link_state_t;
endpackage

// >>> inc/osc_ulpi_if.sv
`timescale 1ns/1ns
`default_nettype none
// Four-bit ULPI style bus between transceiver and link.
interface osc_ulpi_if;
   logic clk_en;
   logic dir;
   logic [3:0] dev_data_o;
   logic [3:0] dev_data_oe_n;
   logic [3:0] link_data_o;
   logic [3:0] link_data_oe_n;
   logic [3:0] data;
   // Bus level resolved from the enables; idle bus reads low.
   assign data = (~dev_data_oe_n & dev_data_o) | (~link_data_oe_n & link_data_o);
   modport dev (output clk_en, output dir, output dev_data_o, output dev_data_oe_n, input data);
   modport link (input clk_en, input dir, output link_data_o, output link_data_oe_n, input data);
endinterface
`default_nettype wire

// >>> testbench/osc_bus_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the bus between transceiver and link.
module osc_bus_assertions (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Bus signals.
   input wire logic clk_en,
   input wire logic dir,
   input wire logic [3:0] dev_data_o,
   input wire logic [3:0] dev_data_oe_n,
   input wire logic [3:0] link_data_o,
   input wire logic [3:0] link_data_oe_n,
   input wire logic [3:0] data
);
   localparam int CMD_WAIT = 6;
   logic boot_done_reg;
   // Remembers the first bus release, so the reset command is expected only once per reset.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         boot_done_reg <= 1'b0;
      end else if (!dir) begin
         boot_done_reg <= 1'b1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Bus rules: both ends never drive together, and the frame shapes are fixed.
   property p_one_driver;
      !(dev_data_oe_n != 4'hF && link_data_oe_n != 4'hF);
   endproperty
   a_one_driver: assert property (p_one_driver) else $error("both ends drive the bus");
   property p_dev_needs_dir;
      dev_data_oe_n != 4'hF |-> dir;
   endproperty
   a_dev_needs_dir: assert property (p_dev_needs_dir) else $error("device drives with direction low");
   property p_link_yields;
      dir && $past(dir) |-> link_data_oe_n == 4'hF;
   endproperty
   a_link_yields: assert property (p_link_yields) else $error("link drives while direction high");
   property p_status_frame;
      $rose(dir) |-> dev_data_oe_n == 4'hF ##1 dev_data_oe_n == 4'h0 ##1 (!dir && dev_data_oe_n == 4'hF);
   endproperty
   a_status_frame: assert property (p_status_frame) else $error("status frame malformed");
   property p_reset_cmd;
      $fell(dir) && !boot_done_reg |-> ##[1:CMD_WAIT] (link_data_oe_n == 4'h0 && data == osc_pkg::CMD_RESET)
         ##1 data == 4'h0;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("no reset command after bus release");
   property p_link_nibble;
      !dir && link_data_oe_n == 4'h0 && data != 4'h0 |-> data == osc_pkg::CMD_RESET
         || data == osc_pkg::CMD_CTRL_WR || $past(data) == osc_pkg::CMD_CTRL_WR;
   endproperty
   a_link_nibble: assert property (p_link_nibble) else $error("stray nonzero link nibble");
   property p_clk_en;
      !$past(rst, 2) |-> clk_en;
   endproperty
   a_clk_en: assert property (p_clk_en) else $error("interface clock enable missing");
   property p_por;
      $fell(rst) |-> (dir && dev_data_oe_n == 4'hF)[*8];
   endproperty
   a_por: assert property (p_por) else $error("bus not blocked after reset");
   c_status: cover property ($rose(dir));
   c_boot: cover property ($fell(dir) && !boot_done_reg);
   c_ctrl: cover property (link_data_oe_n == 4'h0 && data == osc_pkg::CMD_CTRL_WR);
endmodule
`default_nettype wire

// >>> testbench/tb_otg_status_and_session_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_otg_status_and_session_control;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic id_pin = 1'b1;
   logic vbus_valid_cmp = 1'b0;
   logic sess_valid_cmp = 1'b0;
   logic session_end_flag_cmp = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic host_role, irq, id_sense_pull_enable, vbus_discharge_ctrl, vbus_charge_ctrl;
   logic [7:0] rv;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   osc_ulpi_if bus_if ();
   osc_dev osc_dev_inst (.sys_clk(sys_clk), .rst(rst), .id_pin(id_pin), .vbus_valid_cmp(vbus_valid_cmp),
      .sess_valid_cmp(sess_valid_cmp), .session_end_flag_cmp(session_end_flag_cmp), .id_sense_pull_enable(id_sense_pull_enable),
      .vbus_discharge_ctrl(vbus_discharge_ctrl), .vbus_charge_ctrl(vbus_charge_ctrl), .bus(bus_if));
   osc_link osc_link_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_role(host_role), .irq(irq), .bus(bus_if));
   osc_bus_assertions osc_bus_assertions_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(bus_if.clk_en),
      .dir(bus_if.dir), .dev_data_o(bus_if.dev_data_o), .dev_data_oe_n(bus_if.dev_data_oe_n),
      .link_data_o(bus_if.link_data_o), .link_data_oe_n(bus_if.link_data_oe_n), .data(bus_if.data));
   // Free running 25 MHz clock.
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // Prints the verdict and ends the run.
   task automatic summarize();
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe, so it is taken just past that edge.
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   // Bounded wait; the caller judges the level afterwards.
   task automatic wait_sig(ref logic s, input logic v);
      for (int i = 0; i < 300 && s !== v; i++) begin
         @(posedge sys_clk);
      end
   endtask
   task automatic t_boot();
      repeat (40) @(posedge sys_clk);
      rd(osc_pkg::REG_CTRL);
      chk(rv, 8'h00);
      chk({7'h0, id_sense_pull_enable}, 8'h00);
      rd(4'hF);
      chk(rv, 8'h00);
      @(posedge sys_clk);
      id_pin <= 1'b0;
      repeat (20) @(posedge sys_clk);
      rd(osc_pkg::REG_STATUS);
      chk(rv & 8'h0F, 8'h00);
   endtask
   task automatic t_role();
      wr(osc_pkg::REG_IRQ_EN, 8'h05);
      wr(osc_pkg::REG_CTRL, 8'h01);
      wait_sig(id_sense_pull_enable, 1'b1);
      chk({7'h0, id_sense_pull_enable}, 8'h01);
      wait_sig(irq, 1'b1);
      repeat (10) @(posedge sys_clk);
      chk({7'h0, irq}, 8'h01);
      chk({7'h0, host_role}, 8'h00);
      rd(osc_pkg::REG_STATUS);
      chk(rv, 8'h08);
      wr(osc_pkg::REG_IRQ_CLR, 8'h07);
      repeat (40) @(posedge sys_clk);
      chk({7'h0, irq}, 8'h00);
      rd(osc_pkg::REG_IRQ_STAT);
      chk(rv, 8'h00);
      @(posedge sys_clk);
      id_pin <= 1'b1;
      wait_sig(irq, 1'b1);
      repeat (10) @(posedge sys_clk);
      chk({7'h0, host_role}, 8'h01);
      rd(osc_pkg::REG_STATUS);
      chk(rv, 8'h10);
      wr(osc_pkg::REG_IRQ_EN, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk({7'h0, irq}, 8'h00);
      rd(osc_pkg::REG_IRQ_STAT);
      chk(rv & 8'h01, 8'h01);
      wr(osc_pkg::REG_IRQ_CLR, 8'h07);
      @(posedge sys_clk);
      vbus_valid_cmp <= 1'b1;
      repeat (20) @(posedge sys_clk);
      rd(osc_pkg::REG_STATUS);
      chk(rv, 8'h14);
   endtask
   // The request must hold in discharge until session end shows, then charge until session valid.
   task automatic t_srp();
      wr(osc_pkg::REG_IRQ_EN, 8'h02);
      wr(osc_pkg::REG_SRP, 8'h01);
      wait_sig(vbus_discharge_ctrl, 1'b1);
      chk({7'h0, vbus_discharge_ctrl}, 8'h01);
      repeat (30) @(posedge sys_clk);
      chk({7'h0, vbus_charge_ctrl}, 8'h00);
      session_end_flag_cmp <= 1'b1;
      wait_sig(vbus_charge_ctrl, 1'b1);
      chk({7'h0, vbus_charge_ctrl}, 8'h01);
      rd(osc_pkg::REG_STATUS);
      chk(rv & 8'h01, 8'h01);
      @(posedge sys_clk);
      session_end_flag_cmp <= 1'b0;
      sess_valid_cmp <= 1'b1;
      wait_sig(irq, 1'b1);
      rd(osc_pkg::REG_IRQ_STAT);
      chk(rv & 8'h02, 8'h02);
      chk({7'h0, vbus_charge_ctrl}, 8'h00);
   endtask
   // A second reset in mid-run must clear control state and block the bus again.
   task automatic t_reset();
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (40) @(posedge sys_clk);
      chk({7'h0, id_sense_pull_enable}, 8'h00);
      rd(osc_pkg::REG_IRQ_EN);
      chk(rv, 8'h00);
      rd(osc_pkg::REG_STATUS);
      chk(rv & 8'h0F, 8'h06);
   endtask
   // Main sequence.
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      t_boot();
      t_role();
      t_srp();
      t_reset();
      summarize();
   end
   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end
endmodule
`default_nettype wire
